/* include/strap_cfg_pkg.sv */
// strap configuration constants and decoded types
package strap_cfg_pkg;
  localparam int STRAP_W = 9;
  localparam int PLL_SRC_HI = 8;
  localparam int PLL_SRC_LO = 7;
  localparam int DECODE_SET_BIT = 6;
  localparam int ACCESS_BIT = 5;
  localparam int HOST_SEL_HI = 4;
  localparam int HOST_SEL_LO = 0;
  localparam logic [8:0] STRAP_RESET = 9'h000;
  localparam logic [1:0] PLL_AUX = 2'h0;
  localparam logic [1:0] PLL_HOST_BUS_CLOCK = 2'h1;
  localparam logic [1:0] PLL_XTAL1 = 2'h2;
  localparam logic [1:0] PLL_XTAL2 = 2'h3;
  localparam logic [4:0] HSEL_GEN_LE_TRI = 5'h00;
  localparam logic [4:0] HSEL_GEN_LE_DRV = 5'h01;
  localparam logic [4:0] HSEL_GEN_BE_TRI = 5'h04;
  localparam logic [4:0] HSEL_GEN_BE_DRV = 5'h05;
  localparam logic [4:0] HSEL_GEN_BE_HI_TRI = 5'h06;
  localparam logic [4:0] HSEL_ISA_LE_TRI = 5'h08;
  localparam logic [4:0] HSEL_ISA_LE_DRV = 5'h09;
  localparam logic [1:0] BUS_NONE = 2'h0;
  localparam logic [1:0] BUS_GENERIC = 2'h1;
  localparam logic [1:0] BUS_ISA = 2'h2;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_HOLD = 3'b100
  } cap_state_t;
endpackage

/* logic/reset_strap_config_decode.sv */
// strap capture at reset release and static configuration decode
// Behaviour
// - all nine straps sampled once at reset release and used as configuration
// - later strap changes ignored until the next reset release
// - pulled-up strap reads 1, open strap with pull-down reads 0
// - upper two straps pick pll reference: aux, bus clock, crystal one, crystal two
// - code 00000 generic little-endian, wait low tri-state; 00001 wait always driven
// - codes 00100/00101/00110 generic big-endian with listed wait styles
// - code 01000 isa-style little-endian tri-state wait; 01001 always driven
// - this decode applies only when decode set strap reads 0
// - no big-endian operation with indirect access
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_decode
  import strap_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [STRAP_W-1:0] config_straps,
  output logic config_valid,
  output logic [1:0] pll_source_straps,
  output logic decode_set_strap,
  output logic access_style_strap,
  output logic [4:0] host_select_straps,
  output logic indirect_access,
  output logic [1:0] host_bus_kind,
  output logic big_endian,
  output logic wait_active_high,
  output logic wait_always_driven,
  output logic config_supported
);
  typedef struct packed {
    cap_state_t st;
    logic settle;
    logic [STRAP_W-1:0] straps;
    logic [1:0] bus_kind;
    logic big_end;
    logic wait_hi;
    logic wait_drv;
    logic supported;
  } top_state_t;

  top_state_t state_ff;
  top_state_t nxt_state;
  logic [STRAP_W-1:0] straps_sync;

  // pins are asynchronous to core_clk, so they settle through two flops
  strap_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pins_in(config_straps),
    .pins_sync(straps_sync)
  );

  logic [4:0] hsel;
  logic [1:0] d_kind;
  logic d_be;
  logic d_hi;
  logic d_drv;
  logic d_ok;

  always_comb begin
    hsel = straps_sync[HOST_SEL_HI:HOST_SEL_LO];
    d_kind = BUS_NONE;
    d_be = 1'b0;
    d_hi = 1'b0;
    d_drv = 1'b0;
    d_ok = 1'b1;
    case (hsel)
      HSEL_GEN_LE_TRI: d_kind = BUS_GENERIC;
      HSEL_GEN_LE_DRV: begin
        d_kind = BUS_GENERIC;
        d_drv = 1'b1;
      end
      HSEL_GEN_BE_TRI: begin
        d_kind = BUS_GENERIC;
        d_be = 1'b1;
      end
      HSEL_GEN_BE_DRV: begin
        d_kind = BUS_GENERIC;
        d_be = 1'b1;
        d_drv = 1'b1;
      end
      HSEL_GEN_BE_HI_TRI: begin
        d_kind = BUS_GENERIC;
        d_be = 1'b1;
        d_hi = 1'b1;
      end
      HSEL_ISA_LE_TRI: d_kind = BUS_ISA;
      HSEL_ISA_LE_DRV: begin
        d_kind = BUS_ISA;
        d_drv = 1'b1;
      end
      default: d_ok = 1'b0;
    endcase
    // the other decode set is not handled here
    if (straps_sync[DECODE_SET_BIT]) begin
      d_ok = 1'b0;
    end
    // big-endian has no indirect variant
    if (straps_sync[ACCESS_BIT] && d_be) begin
      d_ok = 1'b0;
    end
    if (!d_ok) begin
      d_kind = BUS_NONE;
      d_be = 1'b0;
      d_hi = 1'b0;
      d_drv = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    if (clk_en) begin
      case (state_ff.st)
        // two enabled edges so both synchroniser flops hold post-release pins,
        // not their reset zeros
        ST_RESET: begin
          nxt_state.settle = 1'b1;
          if (state_ff.settle) begin
            nxt_state.st = ST_CAPTURE;
          end
        end
        ST_CAPTURE: begin
          nxt_state.st = ST_HOLD;
          nxt_state.straps = straps_sync;
          nxt_state.bus_kind = d_kind;
          nxt_state.big_end = d_be;
          nxt_state.wait_hi = d_hi;
          nxt_state.wait_drv = d_drv;
          nxt_state.supported = d_ok;
        end
        ST_HOLD: nxt_state.st = ST_HOLD;
        default: nxt_state.st = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff.st <= ST_RESET;
      state_ff.settle <= 1'b0;
      state_ff.straps <= STRAP_RESET;
      state_ff.bus_kind <= BUS_NONE;
      state_ff.big_end <= 1'b0;
      state_ff.wait_hi <= 1'b0;
      state_ff.wait_drv <= 1'b0;
      state_ff.supported <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign config_valid = (state_ff.st == ST_HOLD);
  assign pll_source_straps = state_ff.straps[PLL_SRC_HI:PLL_SRC_LO];
  assign decode_set_strap = state_ff.straps[DECODE_SET_BIT];
  assign access_style_strap = state_ff.straps[ACCESS_BIT];
  assign host_select_straps = state_ff.straps[HOST_SEL_HI:HOST_SEL_LO];
  assign indirect_access = state_ff.straps[ACCESS_BIT];
  assign host_bus_kind = state_ff.bus_kind;
  assign big_endian = state_ff.big_end;
  assign wait_active_high = state_ff.wait_hi;
  assign wait_always_driven = state_ff.wait_drv;
  assign config_supported = state_ff.supported;
endmodule // reset_strap_config_decode
`default_nettype wire

/* logic/strap_sync.sv */
// two-flop synchroniser for the strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_sync
  import strap_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [STRAP_W-1:0] pins_in,
  output logic [STRAP_W-1:0] pins_sync
);
  typedef struct packed {
    logic [STRAP_W-1:0] meta;
    logic [STRAP_W-1:0] sync;
  } sync_state_t;
  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (clk_en) begin
      nxt_state.meta = pins_in;
      nxt_state.sync = state_ff.meta;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pins_sync = state_ff.sync;
endmodule // strap_sync
`default_nettype wire

/* test/host_swap_model.sv */
// host side model: register word as the host places it on the bus
`timescale 1ns/1ps
`default_nettype none
module host_swap_model (
  input wire logic big_endian,
  input wire logic [15:0] reg_word,
  output logic [15:0] bus_word
);
  assign bus_word = big_endian ? {reg_word[7:0], reg_word[15:8]} : reg_word;
endmodule // host_swap_model
`default_nettype wire

/* test/reset_strap_config_decode_test.sv */
// self-checking bench for strap capture and decode
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_decode_test
  import strap_cfg_pkg::*;
  ;
  logic core_clk = 0, resetn = 0, clk_en = 1, probe = 0, prev_valid = 0;
  logic [8:0] config_straps = '0;
  logic config_valid, decode_set_strap, access_style_strap, indirect_access, big_endian;
  logic wait_active_high, wait_always_driven, config_supported;
  logic [1:0] pll_source_straps, host_bus_kind;
  logic [4:0] host_select_straps;
  logic [15:0] reg_word = '0, got, bus_word, exp_word;
  logic [15:0] seen_q[$];
  int err_total = 0, check_count = 0;
  assign got = {pll_source_straps, decode_set_strap, access_style_strap, host_select_straps, indirect_access,
    host_bus_kind, big_endian, wait_active_high, wait_always_driven, config_supported};
  reset_strap_config_decode u_dut (.*);
  host_swap_model u_host (.big_endian(big_endian), .reg_word(reg_word), .bus_word(bus_word));
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [15:0] expect_of(input logic [8:0] s);
    logic [4:0] q;
    case (s[4:0])
      HSEL_GEN_LE_TRI: q = 5'h08;
      HSEL_GEN_LE_DRV: q = 5'h09;
      HSEL_GEN_BE_TRI: q = 5'h0c;
      HSEL_GEN_BE_DRV: q = 5'h0d;
      HSEL_GEN_BE_HI_TRI: q = 5'h0e;
      HSEL_ISA_LE_TRI: q = 5'h10;
      HSEL_ISA_LE_DRV: q = 5'h11;
      default: q = 5'h00;
    endcase
    if (s[6] || (s[5] && q[2])) q = 5'h00;
    return {s, s[5], q, q != 5'h00};
  endfunction
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge core_clk) begin
    if (config_valid === 1'b1 && (!prev_valid || probe)) cmp(seen_q.pop_front(), got);
    prev_valid <= config_valid;
  end
  task automatic run_one(input logic [8:0] s);
    int n = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    // pulled-up straps modelled as driven ones; pull-down disable is software's job
    config_straps = s;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    seen_q.push_back(expect_of(s));
    while (config_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == 20) begin
      err_total++;
      report_and_stop();
    end
    // late pin changes and clock gating must not disturb the held settings
    config_straps = ~s;
    clk_en = 1'($urandom);
    reg_word = 16'($urandom);
    repeat (4) @(posedge core_clk);
    #1 seen_q.push_back(expect_of(s));
    exp_word = expect_of(s);
    exp_word = exp_word[3] ? {reg_word[7:0], reg_word[15:8]} : reg_word;
    cmp(exp_word, bus_word);
    probe = 1'b1;
    @(posedge core_clk);
    #1 probe = 1'b0;
  endtask
  initial begin
    logic [8:0] s;
    void'($urandom(32'h10276dbd));
    for (int i = 0; i < 48; i++) begin
      s = 9'($urandom);
      if (i < 32) s[6:0] = {1'b0, i[4], 1'b0, i[3:0]};
      run_one(s);
    end
    report_and_stop();
  end
endmodule // reset_strap_config_decode_test
`default_nettype wire

/* test/strap_cfg_sva.sv */
// assertions on strap capture and decoded settings
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_sva
  import strap_cfg_pkg::*;
(
  input wire logic core_clk, resetn, clk_en, config_valid, decode_set_strap, access_style_strap,
  input wire logic indirect_access, big_endian, wait_active_high, wait_always_driven, config_supported,
  input wire logic [STRAP_W-1:0] config_straps,
  input wire logic [1:0] pll_source_straps, host_bus_kind,
  input wire logic [4:0] host_select_straps
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_capture;
    !config_valid ##1 config_valid;
  endsequence
  a_capture_all: assert property (s_capture |->
    {pll_source_straps, decode_set_strap, access_style_strap, host_select_straps} == $past(config_straps))
    else $error("captured straps differ from pins");
  a_valid_holds: assert property (config_valid |=> config_valid) else $error("valid dropped");
  a_cfg_frozen: assert property (config_valid ##1 config_valid |->
    $stable({pll_source_straps, host_select_straps, host_bus_kind, big_endian})) else $error("config moved");
  a_access_map: assert property (config_valid |-> indirect_access == access_style_strap)
    else $error("access style wrong");
  a_be_direct: assert property (big_endian |-> config_supported && !indirect_access
    && host_select_straps[4:2] == 3'h1) else $error("big endian misdecoded");
  a_set_one: assert property (decode_set_strap |-> !config_supported && host_bus_kind == BUS_NONE)
    else $error("other decode set accepted");
  a_isa_kind: assert property (host_bus_kind == BUS_ISA |-> host_select_straps[4:1] == 4'h4)
    else $error("isa kind misdecoded");
  a_wait_high: assert property (wait_active_high |-> big_endian && host_select_straps == HSEL_GEN_BE_HI_TRI)
    else $error("wait polarity wrong");
  a_wait_drv: assert property (wait_always_driven |-> config_supported && host_select_straps[0])
    else $error("wait drive wrong");
endmodule // strap_cfg_sva
bind reset_strap_config_decode strap_cfg_sva u_sva (.*);
`default_nettype wire
